// *** design/rft_fifo.sv ***
// parameterised valid/ready fifo of flip-flops
`timescale 1ns/1ps
module rft_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,       // clock
  input  wire logic             rst_n,     // synchronous-released reset
  input  wire logic             flush,     // empty the fifo
  input  wire logic             in_valid,  // write request
  output logic                  in_ready,  // room available
  input  wire logic [WIDTH-1:0] in_data,   // write data
  output logic                  out_valid, // data available
  input  wire logic             out_ready, // reader takes word
  output logic      [WIDTH-1:0] out_data,  // head word
  output logic [$clog2(DEPTH):0] count     // words held
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wptr_reg;
  logic [AW-1:0]    rptr_reg;
  logic [AW:0]      cnt_reg;
  logic             push;
  logic             pop;

  // handshakes
  assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_reg[rptr_reg];
  assign count     = cnt_reg;

  // storage, no reset needed on data
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wptr_reg] <= in_data;
    end
  end

  // pointers and occupancy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg  <= '0;
    end else if (flush) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg  <= '0;
    end else begin
      if (push) begin
        wptr_reg <= (wptr_reg == AW'(DEPTH-1)) ? '0 : wptr_reg + 1'b1;
      end
      if (pop) begin
        rptr_reg <= (rptr_reg == AW'(DEPTH-1)) ? '0 : rptr_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// *** design/rft_pkg.sv ***
// package of register map, field layout and fifo constants for the status/length bank
package rft_pkg;
  // =====================================================================
  // register offsets
  localparam logic [7:0] OFS_STRENGTH_OSC = 8'h0F;
  localparam logic [7:0] OFS_FIFO_STATUS  = 8'h1C;
  localparam logic [7:0] OFS_TX_LEN_HIGH  = 8'h1D;
  localparam logic [7:0] OFS_TX_LEN_LOW   = 8'h1E;
  // =====================================================================
  // field positions
  localparam int OSC_OK_BIT      = 6;
  localparam int AUX_STRENGTH_LO = 3;
  localparam int ACT_STRENGTH_LO = 0;
  localparam int FIFO_HIGH_BIT   = 6;
  localparam int FIFO_LOW_BIT    = 5;
  localparam int FIFO_OVF_BIT    = 4;
  localparam int PARTIAL_FLAG    = 0;
  localparam int PARTIAL_BITS_LO = 1;
  localparam int AM_PM_SWAP_BIT  = 3;
  // =====================================================================
  // reset values and fifo levels
  localparam logic [7:0] TX_LEN_RESET   = 8'h00;
  localparam int         FIFO_DEPTH_B   = 12;
  localparam int         FIFO_HIGH_LVL  = 9;
  localparam int         FIFO_LOW_LVL   = 3;
  localparam int         IRQ_LOW_BELOW  = 4;
  localparam int         IRQ_HIGH_ABOVE = 8;
  localparam int         BUF_DEPTH      = 16;

  // one strength measurement from the analog receive path
  typedef struct packed {
    logic       valid;    // new measurement strobe
    logic [2:0] am_level; // am demodulator level code
    logic [2:0] pm_level; // pm demodulator level code
  } rft_strength_t;

  // host register access request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rft_reg_req_t;
endpackage

// *** design/rft_status_regs.sv ***
// status, fifo and transmit length register bank of the reader front end
// What this block does
// [R1] strength readings update from reception start until the next transmission starts, then hold
// [R2] oscillator stable indication shows on bit 6 of strength register
// [R3] auxiliary strength code in bits 5..3; pm, or am when swap bit set
// [R4] active strength code in bits 2..0; am, or pm when swap bit set
// [R5] fifo high flag, bit 6, when nine bytes held during reception
// [R6] fifo low flag, bit 5, when three bytes remain during transmission
// [R7] overflow flag, bit 4, when receiver offers a byte while fifo is full
// [R8] fifo status bits 3..0 show unread bytes minus one
// [R9] fifo status bit 7 is reserved and reads zero
// [R10] first length register holds count bits 11..4
// [R11] second length register bits 7..4 hold count bits 3..0
// [R12] length registers clear at reset and while enable is low
// [R13] length registers clear when transmit end of frame is sent
// [R14] bits 3..1 give partial byte bit count, used only when flag set
// [R15] bit 0 set marks last byte shorter than eight bits
// [R16] fifo interrupt cause when fewer than four or more than eight bytes
// [R17] reset command empties fifo, clears fifo status and collision position; an overflow set in the same cycle wins over the clear
// [R18] byte count follows every receiver push and framer pop at once
// [R19] levels and overflow judged against a twelve byte fifo
`timescale 1ns/1ps
module rft_status_regs
  import rft_pkg::*;
#(
  parameter int FIFO_BYTES = FIFO_DEPTH_B // usable fifo depth in bytes
) (
  input  wire logic          mclk,           // 250 MHz clock
  input  wire logic          rstn,           // power-on reset, active low
  input  wire logic          enable,         // enable pin, async
  input  wire logic          osc_stable,     // crystal stable, async
  input  wire rft_reg_req_t  reg_req,        // host register access
  output logic        [7:0]  reg_rdata,      // read data, registered
  input  wire logic          chip_swap_ampm, // control bit 3 of chip state
  input  wire rft_strength_t strength_in,    // measurement from receiver
  input  wire logic          rx_start,       // reception start pulse
  input  wire logic          tx_start,       // transmission start pulse
  input  wire logic          tx_active,      // transmit in progress level
  input  wire logic          rx_active,      // receive in progress level
  input  wire logic          tx_eof_sent,    // transmit end of frame pulse
  input  wire logic          reset_cmd,      // reset direct command pulse
  input  wire logic          rx_byte_valid,  // receiver delivers byte
  input  wire logic    [7:0] rx_byte,        // received byte
  output logic               rx_byte_ready,  // fifo can take receiver byte
  output logic               tx_byte_valid,  // byte available for framer
  input  wire logic          tx_byte_ready,  // framer takes byte
  output logic         [7:0] tx_byte,        // byte to framer
  output logic        [11:0] tx_byte_count,  // complete bytes to send
  output logic               tx_partial,     // last byte is partial
  output logic         [2:0] tx_partial_bits,// bits of last partial byte
  output logic               fifo_irq_cause, // fifo level interrupt cause
  output logic               col_pos_clear   // clear collision position
);
  // =====================================================================
  // reset and input synchronisers
  logic [1:0] rst_sync_reg;
  logic       rst_n;
  logic [1:0] en_sync_reg;
  logic [1:0] osc_sync_reg;
  logic       en_low;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // pins cross in through two flops each
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      en_sync_reg  <= 2'h0;
      osc_sync_reg <= 2'h0;
    end else begin
      en_sync_reg  <= {en_sync_reg[0], enable};
      osc_sync_reg <= {osc_sync_reg[0], osc_stable};
    end
  end
  assign en_low = ~en_sync_reg[1];

  // =====================================================================
  // fifo between receiver and transmit framer
  localparam int CW = $clog2(BUF_DEPTH) + 1;
  logic          host_fifo_wr;
  logic          host_fifo_rd;
  logic          fifo_in_valid;
  logic          fifo_in_ready;
  logic    [7:0] fifo_in_data;
  logic          fifo_out_valid;
  logic          fifo_out_ready;
  logic    [7:0] fifo_out_data;
  logic [CW-1:0] fifo_cnt;
  logic          fifo_has_room;
  logic          fifo_flush;

  // host fifo data port is not modelled: host write and read strobes are tied low,
  // so host register accesses never push into or pop from the fifo
  assign host_fifo_wr  = 1'b0;
  assign host_fifo_rd  = 1'b0;
  // usable depth is twelve bytes even though the buffer has sixteen slots
  assign fifo_has_room = (fifo_cnt < CW'(FIFO_BYTES));                     // [R19]
  assign fifo_in_valid = rx_byte_valid & fifo_has_room;
  assign fifo_in_data  = rx_byte;
  assign rx_byte_ready = fifo_in_ready & fifo_has_room;
  assign tx_byte_valid = fifo_out_valid & tx_active;
  assign fifo_out_ready= tx_byte_ready & tx_active;
  assign tx_byte       = fifo_out_data;
  assign fifo_flush    = reset_cmd | en_low;                              // [R17]
  assign col_pos_clear = reset_cmd;                                       // [R17]

  rft_fifo #(
    .WIDTH (8),
    .DEPTH (BUF_DEPTH)
  ) u_fifo (
    .clk       (mclk),
    .rst_n     (rst_n),
    .flush     (fifo_flush),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data),
    .count     (fifo_cnt)
  );

  // =====================================================================
  // overflow detection: receiver bytes offered to a full fifo
  logic wr_ovf_attempt;
  logic ovf_reg;
  logic host_push_lost;

  // a receiver byte offered while full counts as too much data
  assign host_push_lost = rx_byte_valid & ~fifo_has_room;
  assign wr_ovf_attempt = host_push_lost | host_fifo_wr | host_fifo_rd;

  // sticky overflow; set wins over the clearing command
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_reg <= 1'b0;
    end else if (wr_ovf_attempt) begin
      ovf_reg <= 1'b1;                                                    // [R7]
    end else if (fifo_flush) begin
      ovf_reg <= 1'b0;                                                    // [R17]
    end
  end

  // =====================================================================
  // fifo status composition, combinational from live occupancy
  logic [7:0] fifo_status;
  logic [3:0] unread_m1;
  logic       lvl_high;
  logic       lvl_low;

  // count follows the fifo counter directly, so every push/pop shows at once
  assign unread_m1 = (fifo_cnt == '0) ? 4'h0 : 4'(fifo_cnt - CW'(1));    // [R8] [R18]
  assign lvl_high  = rx_active & (fifo_cnt >= CW'(FIFO_HIGH_LVL));        // [R5]
  assign lvl_low   = tx_active & (fifo_cnt <= CW'(FIFO_LOW_LVL));         // [R6]

  always_comb begin
    fifo_status                = 8'h00;                                   // [R9]
    fifo_status[FIFO_HIGH_BIT] = lvl_high;
    fifo_status[FIFO_LOW_BIT]  = lvl_low;
    fifo_status[FIFO_OVF_BIT]  = ovf_reg;
    fifo_status[3:0]           = unread_m1;
  end

  // fifo cause on level alone: under four or over eight bytes
  // masking it while idle is left to the interrupt logic outside this bank
  assign fifo_irq_cause = (fifo_cnt < CW'(IRQ_LOW_BELOW)) |
                          (fifo_cnt > CW'(IRQ_HIGH_ABOVE));               // [R16]

  // =====================================================================
  // signal strength hold
  logic [2:0] act_level_reg;
  logic [2:0] aux_level_reg;
  logic       strength_open_reg;

  // window opens at reception start and closes at next transmit start
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      strength_open_reg <= 1'b0;
    end else if (rx_start) begin
      strength_open_reg <= 1'b1;                                          // [R1]
    end else if (tx_start) begin
      strength_open_reg <= 1'b0;                                          // [R1]
    end
  end

  // capture only inside the window so readings stay frozen afterwards
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      act_level_reg <= 3'h0;
      aux_level_reg <= 3'h0;
    end else if (strength_in.valid & (strength_open_reg | rx_start)) begin
      if (chip_swap_ampm) begin
        act_level_reg <= strength_in.pm_level;                            // [R4]
        aux_level_reg <= strength_in.am_level;                            // [R3]
      end else begin
        act_level_reg <= strength_in.am_level;                            // [R4]
        aux_level_reg <= strength_in.pm_level;                            // [R3]
      end
    end
  end

  logic [7:0] strength_status;
  always_comb begin
    strength_status                                  = 8'h00;
    strength_status[OSC_OK_BIT]                      = osc_sync_reg[1];   // [R2]
    strength_status[AUX_STRENGTH_LO+2:AUX_STRENGTH_LO] = aux_level_reg;   // [R3]
    strength_status[ACT_STRENGTH_LO+2:ACT_STRENGTH_LO] = act_level_reg;   // [R4]
  end

  // =====================================================================
  // transmit length registers
  logic [7:0] tx_len_high_reg;
  logic [7:0] tx_len_low_reg;

  // enable low and end of frame both win over a host write
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_len_high_reg <= TX_LEN_RESET;                                    // [R12]
      tx_len_low_reg  <= TX_LEN_RESET;
    end else if (en_low) begin
      tx_len_high_reg <= TX_LEN_RESET;                                    // [R12]
      tx_len_low_reg  <= TX_LEN_RESET;
    end else if (tx_eof_sent) begin
      tx_len_high_reg <= TX_LEN_RESET;                                    // [R13]
      tx_len_low_reg  <= TX_LEN_RESET;
    end else if (reg_req.wr) begin
      if (reg_req.addr == OFS_TX_LEN_HIGH) begin
        tx_len_high_reg <= reg_req.wdata;                                 // [R10]
      end
      if (reg_req.addr == OFS_TX_LEN_LOW) begin
        tx_len_low_reg <= reg_req.wdata;                                  // [R11]
      end
    end
  end

  // count assembled from both registers; partial bits gated by the flag
  assign tx_byte_count   = {tx_len_high_reg, tx_len_low_reg[7:4]};        // [R10] [R11]
  assign tx_partial      = tx_len_low_reg[PARTIAL_FLAG];                  // [R15]
  assign tx_partial_bits = tx_partial ?
                           tx_len_low_reg[PARTIAL_BITS_LO+2:PARTIAL_BITS_LO] : 3'h0; // [R14]

  // =====================================================================
  // read data, registered one cycle after the read request
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        OFS_STRENGTH_OSC: reg_rdata <= strength_status;
        OFS_FIFO_STATUS:  reg_rdata <= fifo_status;
        OFS_TX_LEN_HIGH:  reg_rdata <= tx_len_high_reg;
        OFS_TX_LEN_LOW:   reg_rdata <= tx_len_low_reg;
        default:          reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule

// *** tb/rft_host_model.sv ***
// host controller model issuing register accesses to the bank
`timescale 1ns/1ps
module rft_host_model
  import rft_pkg::*;
(
  input  wire logic         mclk,    // clock
  output rft_reg_req_t      reg_req, // access strobe to the bank
  input  wire logic   [7:0] rdata    // registered read data
);
  initial reg_req = '0;
  // one access; idle bus shows inverted address and data so stale values never look valid
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge mclk) reg_req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge mclk) reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    @(negedge mclk) q = rdata;
  endtask
  // the 12-bit count is split over both length registers
  task automatic set_len(input logic [11:0] n, input logic [2:0] bb, input logic bf);
    logic [7:0] q;
    access(1'b1, OFS_TX_LEN_HIGH, n[11:4], q);
    access(1'b1, OFS_TX_LEN_LOW, {n[3:0], bb, bf}, q);
  endtask
endmodule

// *** tb/rft_status_regs_asserts.sv ***
// port checker of the status and length register bank
`timescale 1ns/1ps
module rft_status_regs_asserts
  import rft_pkg::*;
#(
  parameter int FIFO_BYTES = FIFO_DEPTH_B // usable fifo depth
) (
  input wire logic         mclk,            // clock
  input wire logic         rstn,            // reset, active low
  input wire logic         enable,          // enable pin
  input wire logic         osc_stable,      // crystal stable
  input wire rft_reg_req_t reg_req,         // host access
  input wire logic  [7:0]  reg_rdata,       // read data
  input wire logic         rx_active,       // receive level
  input wire logic         tx_active,       // transmit level
  input wire logic         tx_eof_sent,     // end of frame pulse
  input wire logic         reset_cmd,       // reset command
  input wire logic         rx_byte_valid,   // receiver offers byte
  input wire logic         rx_byte_ready,   // fifo takes byte
  input wire logic  [11:0] tx_byte_count,   // length out
  input wire logic         tx_partial,      // partial flag out
  input wire logic  [2:0]  tx_partial_bits, // partial bits out
  input wire logic         fifo_irq_cause,  // fifo level cause
  input wire logic         col_pos_clear    // collision clear
);
  // ==========================================================
  // helpers: the bank only listens once both synchronisers settle
  logic [3:0] up_q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) up_q <= 4'h0;
    else up_q <= {up_q[2:0], 1'b1};
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence s_live;
    up_q[3] && enable && $past(enable) && $past(enable, 2);
  endsequence
  sequence s_wr(a);
    s_live ##0 reg_req.wr && reg_req.addr == a && !tx_eof_sent;
  endsequence
  sequence s_rd_stat;
    reg_req.rd && reg_req.addr == OFS_FIFO_STATUS && !reset_cmd;
  endsequence
  // ==========================================================
  // assertions
  a_len_hi_write: assert property (s_wr(OFS_TX_LEN_HIGH) |=> tx_byte_count[11:4] == $past(reg_req.wdata))
    else $error("high length write not seen");
  a_len_lo_write: assert property (s_wr(OFS_TX_LEN_LOW) |=> {tx_byte_count[3:0], tx_partial} ==
    {$past(reg_req.wdata[7:4]), $past(reg_req.wdata[0])}) else $error("low length write not seen");
  a_partial_bits: assert property (s_wr(OFS_TX_LEN_LOW) ##0 reg_req.wdata[0] |=>
    tx_partial_bits == $past(reg_req.wdata[3:1])) else $error("partial bit count wrong");
  a_len_eof_clear: assert property (tx_eof_sent |=> tx_byte_count == 12'h000 && !tx_partial)
    else $error("length not cleared at end of frame");
  a_len_en_clear: assert property ((!enable)[*4] |-> tx_byte_count == 12'h000 && !tx_partial)
    else $error("length not cleared while disabled");
  a_stat_reserved: assert property (reg_req.rd && reg_req.addr == OFS_FIFO_STATUS |=> !reg_rdata[7])
    else $error("reserved status bit set");
  a_osc_shown: assert property (osc_stable[*4] ##0 up_q[3] && reg_req.rd && reg_req.addr == OFS_STRENGTH_OSC
    |=> reg_rdata[6]) else $error("oscillator flag missing");
  a_ovf_sticky: assert property (s_live ##0 rx_byte_valid && !rx_byte_ready ##1 enable && !reset_cmd
    ##1 enable ##0 s_rd_stat |=> reg_rdata[4]) else $error("overflow flag missing");
  a_full_flags: assert property (s_live ##0 !rx_byte_ready && rx_active && !tx_active ##0 s_rd_stat
    |=> reg_rdata[6] && reg_rdata[3:0] == 4'hB) else $error("full fifo status wrong");
  a_irq_full: assert property (s_live ##0 !rx_byte_ready |-> fifo_irq_cause)
    else $error("full fifo without level cause");
  a_col_clear: assert property (col_pos_clear == reset_cmd)
    else $error("collision clear not tied to reset command");
endmodule
bind rft_status_regs rft_status_regs_asserts #(.FIFO_BYTES(FIFO_BYTES)) chk (.mclk(mclk), .rstn(rstn),
  .enable(enable), .osc_stable(osc_stable), .reg_req(reg_req), .reg_rdata(reg_rdata), .rx_active(rx_active),
  .tx_active(tx_active), .tx_eof_sent(tx_eof_sent), .reset_cmd(reset_cmd), .rx_byte_valid(rx_byte_valid),
  .rx_byte_ready(rx_byte_ready), .tx_byte_count(tx_byte_count), .tx_partial(tx_partial),
  .tx_partial_bits(tx_partial_bits), .fifo_irq_cause(fifo_irq_cause), .col_pos_clear(col_pos_clear));

// *** tb/test_rft_status_regs.sv ***
// self-checking bench of the status and length register bank
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module test_rft_status_regs
  import rft_pkg::*;
;
  logic mclk, rstn, enable, osc_stable, chip_swap_ampm, rx_start, tx_start, tx_active, rx_active, ovf, bf;
  logic tx_eof_sent, reset_cmd, rx_byte_valid, tx_byte_ready, rx_byte_ready, tx_byte_valid, tx_partial;
  logic fifo_irq_cause, col_pos_clear;
  logic [7:0]    rx_byte, tx_byte, reg_rdata, q, sb[$];
  logic [11:0]   tx_byte_count, n;
  logic [2:0]    tx_partial_bits, bb, am, pm;
  rft_reg_req_t  reg_req;
  rft_strength_t strength_in;
  int            n_errors = 0;
  int            n_compared = 0;
  rft_status_regs #(.FIFO_BYTES(12)) uut (.mclk(mclk), .rstn(rstn), .enable(enable), .osc_stable(osc_stable),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .chip_swap_ampm(chip_swap_ampm), .strength_in(strength_in),
    .rx_start(rx_start), .tx_start(tx_start), .tx_active(tx_active), .rx_active(rx_active),
    .tx_eof_sent(tx_eof_sent), .reset_cmd(reset_cmd), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
    .rx_byte_ready(rx_byte_ready), .tx_byte_valid(tx_byte_valid), .tx_byte_ready(tx_byte_ready),
    .tx_byte(tx_byte), .tx_byte_count(tx_byte_count), .tx_partial(tx_partial),
    .tx_partial_bits(tx_partial_bits), .fifo_irq_cause(fifo_irq_cause), .col_pos_clear(col_pos_clear));
  rft_host_model host (.mclk(mclk), .reg_req(reg_req), .rdata(reg_rdata));
  // ==========================================================
  // clock, watchdog and helpers
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    wrap_up();
  end
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // expected status: 9 held while receiving, 3 left while sending, count shown minus one
  function automatic logic [7:0] exp_stat(int k);
    exp_stat = {1'b0, rx_active && k >= 9, tx_active && k <= 3, ovf, k == 0 ? 4'h0 : 4'(k - 1)};
  endfunction
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    host.access(1'b0, a, 8'h00, d);
  endtask
  task automatic chk_fifo();
    rd(OFS_FIFO_STATUS, q);
    `CHK(q, exp_stat(sb.size()))
    `CHK(fifo_irq_cause, sb.size() < 4 || sb.size() > 8)
    `CHK(rx_byte_ready, sb.size() < 12)
  endtask
  // a byte offered at full is dropped and marks overflow
  task automatic push(input logic [7:0] b);
    @(posedge mclk) rx_byte_valid <= 1'b1;
    rx_byte <= b;
    @(posedge mclk) rx_byte_valid <= 1'b0;
    rx_byte <= ~b;
    if (sb.size() < 12) sb.push_back(b);
    else ovf = 1'b1;
  endtask
  // framer stalls a random while before taking the head byte
  task automatic pop();
    repeat ($urandom_range(3)) @(posedge mclk);
    @(negedge mclk);
    `CHK(tx_byte_valid, 1'b1)
    q = sb.pop_front();
    `CHK(tx_byte, q)
    @(posedge mclk) tx_byte_ready <= 1'b1;
    @(posedge mclk) tx_byte_ready <= 1'b0;
  endtask
  // ==========================================================
  // tests
  initial begin
    {rstn, enable, osc_stable, chip_swap_ampm, rx_start, tx_start, tx_active, rx_active} = '0;
    {tx_eof_sent, reset_cmd, rx_byte_valid, tx_byte_ready, rx_byte, strength_in, ovf} = '0;
    q = $urandom(32'h592C);
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    enable <= 1'b1;
    repeat (6) @(posedge mclk);
    rd(OFS_TX_LEN_HIGH, q);
    `CHK(q, 8'h00)
    rd(OFS_TX_LEN_LOW, q);
    `CHK(q, 8'h00)
    rd(8'h20, q);
    `CHK(q, 8'h00)
    host.access(1'b1, OFS_FIFO_STATUS, 8'hFF, q);
    chk_fifo();
    $display("test reset_map finished");
    for (int i = 0; i < 6; i++) begin
      n = (i == 0) ? 12'hFFF : 12'($urandom);
      bb = 3'($urandom);
      bf = (i == 0) || $urandom_range(1);
      host.set_len(n, bb, bf);
      `CHK(tx_byte_count, n)
      `CHK(tx_partial, bf)
      if (bf) `CHK(tx_partial_bits, bb)
      rd(OFS_TX_LEN_LOW, q);
      `CHK(q, {n[3:0], bb, bf})
    end
    // a write landing with the end of frame must lose
    fork
      host.access(1'b1, OFS_TX_LEN_HIGH, 8'h5A, q);
      begin
        @(posedge mclk) tx_eof_sent <= 1'b1;
        @(posedge mclk) tx_eof_sent <= 1'b0;
      end
    join
    `CHK({tx_byte_count, tx_partial}, 13'h0)
    host.set_len(12'hA53, 3'h5, 1'b1);
    @(posedge mclk) enable <= 1'b0;
    repeat (5) @(posedge mclk);
    `CHK({tx_byte_count, tx_partial}, 13'h0)
    enable <= 1'b1;
    repeat (4) @(posedge mclk);
    $display("test length finished");
    for (int s = 0; s < 2; s++) begin
      am = 3'($urandom);
      pm = 3'($urandom);
      @(posedge mclk) chip_swap_ampm <= 1'(s);
      osc_stable <= 1'(s);
      rx_start <= 1'b1;
      @(posedge mclk) rx_start <= 1'b0;
      strength_in <= {1'b1, am, pm};
      @(posedge mclk) strength_in <= {1'b0, am, pm};
      repeat (3) @(posedge mclk);
      rd(OFS_STRENGTH_OSC, q);
      `CHK(q, {1'b0, 1'(s), s ? {am, pm} : {pm, am}})
      @(posedge mclk) tx_start <= 1'b1;
      @(posedge mclk) tx_start <= 1'b0;
      strength_in <= {1'b1, ~am, ~pm};
      @(posedge mclk) strength_in <= '0;
      rd(OFS_STRENGTH_OSC, q);
      `CHK(q, {1'b0, 1'(s), s ? {am, pm} : {pm, am}})
    end
    $display("test strength finished");
    @(posedge mclk) rx_active <= 1'b1;
    for (int i = 0; i < 13; i++) begin
      push(i == 12 ? 8'hFF : 8'($urandom));
      chk_fifo();
    end
    @(posedge mclk) rx_active <= 1'b0;
    tx_active <= 1'b1;
    while (sb.size() > 0) begin
      pop();
      chk_fifo();
    end
    @(posedge mclk) tx_active <= 1'b0;
    rx_active <= 1'b1;
    push(8'h3C);
    push(8'hC3);
    @(posedge mclk) reset_cmd <= 1'b1;
    @(negedge mclk);
    `CHK(col_pos_clear, 1'b1)
    @(posedge mclk) reset_cmd <= 1'b0;
    sb.delete();
    ovf = 1'b0;
    chk_fifo();
    $display("test fifo finished");
    wrap_up();
  end
endmodule
